// *** design/dual_programmable_timer.v ***
// Contract
// - prescaler source bit 0 picks low-speed clock, 1 picks high-speed, one bit per timer
// - in event mode timer 0 ignores its source and divide bits
// - divide code 11 gives /256, 10 /32, 01 /4, 00 /1
// - timer 0 counts external pulses when mode bit is 1, prescaled clock when 0
// - noise rejecter accepts a level change at second 2048 Hz falling edge
// - rejecter bit 0 counts pin directly; bit matters only in event mode
// - event edge: falling when polarity bit 0, rising when 1
// - counter counts down from reload; reload on preset write and on underflow
// - reading low count nibble latches high nibble for later read
// - count nibbles are read-only; writes ignored
// - preset loads reload; running timer keeps counting, stopped timer holds
// - preset bits are write-only, read as 0, writing 0 does nothing
// - run bit 1 counts, 0 stops and holds; counting resumes from held value
// - channel select 0 routes timer 0 underflows to output, 1 timer 1
// - output enable 1 drives output signal on pin, 0 holds pin high
// - interrupt mask bit 1 enables, 0 masks, per timer
// - reset clears control, select, mask bits, reload and count values
// - flag set on every underflow even masked; write 1 clears, 0 ignored
// - run/stop acts at next input clock tick; run bit reads 1 until stopped
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dual_timer_map.vh"

module dual_programmable_timer #(
	parameter ADDR_W = 18
) (
	// clock and reset
	input  wire              clk,
	input  wire              sys_rst,
	// axi4-lite write address and data
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// axi4-lite read
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// oscillator and event inputs, sampled on clk
	input  wire              low_speed_clock,
	input  wire              high_speed_clock,
	input  wire              rejecter_clock_2048hz,
	input  wire              event_input_pin,
	// outputs
	output reg               timer_output_signal,
	output reg               shared_output_pin,
	output wire              timer0_irq,
	output wire              timer1_irq
);

	// ********************************
	// helper functions
	// ********************************

	// prescaler tick for a given division code
	function psc_tick;
		input [7:0] cnt;
		input [1:0] div;
		begin
			case (div)
				`DIV_BY_1:   psc_tick = 1'b1;
				`DIV_BY_4:   psc_tick = (cnt[1:0] == 2'h3);
				`DIV_BY_32:  psc_tick = (cnt[4:0] == 5'h1F);
				default:     psc_tick = (cnt == 8'hFF);
			endcase
		end
	endfunction

	// word-aligned index decode
	function [15:0] addr_idx;
		input [ADDR_W-1:0] a;
		begin
			addr_idx = a[17:2];
		end
	endfunction

	// ********************************
	// register state
	// ********************************

	reg        ev_mode_r;
	reg        ev_noise_r;
	reg        ev_pol_r;
	reg  [1:0] cksel_r;
	reg        out_en_r;
	reg        output_channel_select_r;
	reg  [1:0] div0_r;
	reg  [1:0] div1_r;
	reg  [1:0] run_req_r;
	reg  [1:0] run_act_r;
	reg  [7:0] rld0_r;
	reg  [7:0] rld1_r;
	reg  [7:0] cnt0_r;
	reg  [7:0] cnt1_r;
	reg  [3:0] hold0_r;
	reg  [3:0] hold1_r;
	reg  [1:0] irq_en_r;
	reg  [1:0] irq_flag_r;

	// ********************************
	// axi4-lite slave
	// ********************************

	reg                aw_full_r;
	reg  [ADDR_W-1:0]  aw_addr_r;
	reg                w_full_r;
	reg  [31:0]        w_data_r;
	reg  [3:0]         w_strb_r;
	wire               do_wr;
	wire               wr_lane;
	wire [15:0]        wr_idx;
	wire [3:0]         wd;
	wire               ar_go;
	wire [15:0]        rd_idx;
	reg  [3:0]         rd_nib;
	reg                rd_hit;
	reg                wr_hit;

	// one write at a time: hold both halves until the response leaves
	assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
	assign do_wr         = aw_full_r & w_full_r & ~s_axi_bvalid;
	assign wr_idx        = addr_idx(aw_addr_r);
	assign wr_lane       = w_strb_r[0] & (aw_addr_r[1:0] == 2'h0);
	assign wd            = w_data_r[3:0];
	assign s_axi_arready = ~s_axi_rvalid;
	assign ar_go         = s_axi_arvalid & s_axi_arready;
	assign rd_idx        = addr_idx(s_axi_araddr);

	// write channel capture and response
	always @(posedge clk) begin
		if (sys_rst) begin
			aw_full_r    <= 1'b0;
			aw_addr_r    <= {ADDR_W{1'b0}};
			w_full_r     <= 1'b0;
			w_data_r     <= 32'h00000000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// write address decode; count nibbles are known but take no data
	always @* begin
		case (wr_idx)
			`IDX_EVCFG, `IDX_CLKOUT, `IDX_T0CTRL, `IDX_T1CTRL,
			`IDX_T0RLD_LO, `IDX_T0RLD_HI, `IDX_T1RLD_LO, `IDX_T1RLD_HI,
			`IDX_T0CNT_LO, `IDX_T0CNT_HI, `IDX_T1CNT_LO, `IDX_T1CNT_HI,
			`IDX_IRQ_EN, `IDX_IRQ_FLAG: wr_hit = (aw_addr_r[1:0] == 2'h0);
			default:                    wr_hit = 1'b0;
		endcase
	end

	// read mux; preset bits and unused bits read as zero
	always @* begin
		rd_hit = 1'b1;
		case (rd_idx)
			`IDX_EVCFG:    rd_nib = {1'b0, ev_mode_r, ev_noise_r, ev_pol_r};
			`IDX_CLKOUT:   rd_nib = {output_channel_select_r, out_en_r, cksel_r};
			`IDX_T0CTRL:   rd_nib = {div0_r, 1'b0, run_req_r[0] | run_act_r[0]};
			`IDX_T1CTRL:   rd_nib = {div1_r, 1'b0, run_req_r[1] | run_act_r[1]};
			`IDX_T0RLD_LO: rd_nib = rld0_r[3:0];
			`IDX_T0RLD_HI: rd_nib = rld0_r[7:4];
			`IDX_T1RLD_LO: rd_nib = rld1_r[3:0];
			`IDX_T1RLD_HI: rd_nib = rld1_r[7:4];
			`IDX_T0CNT_LO: rd_nib = cnt0_r[3:0];
			`IDX_T0CNT_HI: rd_nib = hold0_r;
			`IDX_T1CNT_LO: rd_nib = cnt1_r[3:0];
			`IDX_T1CNT_HI: rd_nib = hold1_r;
			`IDX_IRQ_EN:   rd_nib = {2'h0, irq_en_r};
			`IDX_IRQ_FLAG: rd_nib = {2'h0, irq_flag_r};
			default: begin
				rd_nib = 4'h0;
				rd_hit = 1'b0;
			end
		endcase
		if (s_axi_araddr[1:0] != 2'h0)
			rd_hit = 1'b0;
	end

	// read answer one cycle after the address is taken
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (ar_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {28'h0000000, rd_hit ? rd_nib : 4'h0};
			s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ********************************
	// clock sources and prescalers
	// ********************************

	reg        ls_prev_r;
	reg        hs_prev_r;
	reg  [7:0] psc0_r;
	reg  [7:0] psc1_r;
	wire       ls_fall;
	wire       hs_fall;
	wire [1:0] src_fall;
	wire [1:0] tick;

	assign ls_fall     = ls_prev_r & ~low_speed_clock;
	assign hs_fall     = hs_prev_r & ~high_speed_clock;
	assign src_fall[0] = cksel_r[0] ? hs_fall : ls_fall;
	assign src_fall[1] = cksel_r[1] ? hs_fall : ls_fall;
	assign tick[1]     = src_fall[1] & psc_tick(psc1_r, div1_r);

	// free dividers advance on falling edges of their chosen source
	always @(posedge clk) begin
		if (sys_rst) begin
			ls_prev_r <= 1'b0;
			hs_prev_r <= 1'b0;
			psc0_r    <= `RST_BYTE;
			psc1_r    <= `RST_BYTE;
		end else begin
			ls_prev_r <= low_speed_clock;
			hs_prev_r <= high_speed_clock;
			if (src_fall[0])
				psc0_r <= psc0_r + 8'h01;
			if (src_fall[1])
				psc1_r <= psc1_r + 8'h01;
		end
	end

	// ********************************
	// event input path of timer 0
	// ********************************

	reg  rj_prev_r;
	reg  filt_r;
	reg  pend_r;
	reg  ev_prev_r;
	wire rj_fall;
	wire ev_level;
	wire ev_edge;

	assign rj_fall  = rj_prev_r & ~rejecter_clock_2048hz;
	assign ev_level = ev_noise_r ? filt_r : event_input_pin;
	assign ev_edge  = ev_pol_r ? (~ev_prev_r & ev_level)
	                           : (ev_prev_r & ~ev_level);
	// mode bit picks event edges, so source and divide bits drop out
	assign tick[0]  = ev_mode_r ? ev_edge
	                            : (src_fall[0] & psc_tick(psc0_r, div0_r));

	// a changed level must persist across two rejecter falling edges
	always @(posedge clk) begin
		if (sys_rst) begin
			rj_prev_r <= 1'b0;
			filt_r    <= 1'b0;
			pend_r    <= 1'b0;
			ev_prev_r <= 1'b0;
		end else begin
			rj_prev_r <= rejecter_clock_2048hz;
			ev_prev_r <= ev_level;
			if (rj_fall) begin
				if (event_input_pin != filt_r) begin
					pend_r <= ~pend_r;
					if (pend_r)
						filt_r <= event_input_pin;
				end else begin
					pend_r <= 1'b0;
				end
			end
		end
	end

	// ********************************
	// counters
	// ********************************

	wire [1:0] preset_wr;
	wire [1:0] uf;

	assign preset_wr[0] = do_wr & wr_lane & (wr_idx == `IDX_T0CTRL) & wd[`TC_PRESET_BIT];
	assign preset_wr[1] = do_wr & wr_lane & (wr_idx == `IDX_T1CTRL) & wd[`TC_PRESET_BIT];
	// underflow: a live tick that finds the counter at zero
	assign uf[0] = tick[0] & run_act_r[0] & (cnt0_r == 8'h00) & ~preset_wr[0];
	assign uf[1] = tick[1] & run_act_r[1] & (cnt1_r == 8'h00) & ~preset_wr[1];

	// run state follows the request only on a tick, after the decrement
	always @(posedge clk) begin
		if (sys_rst) begin
			run_act_r <= 2'h0;
			cnt0_r    <= `RST_BYTE;
			cnt1_r    <= `RST_BYTE;
		end else begin
			if (tick[0])
				run_act_r[0] <= run_req_r[0];
			if (tick[1])
				run_act_r[1] <= run_req_r[1];
			if (preset_wr[0])
				cnt0_r <= rld0_r;
			else if (uf[0])
				cnt0_r <= rld0_r;
			else if (tick[0] & run_act_r[0])
				cnt0_r <= cnt0_r - 8'h01;
			if (preset_wr[1])
				cnt1_r <= rld1_r;
			else if (uf[1])
				cnt1_r <= rld1_r;
			else if (tick[1] & run_act_r[1])
				cnt1_r <= cnt1_r - 8'h01;
		end
	end

	// ********************************
	// software-written registers
	// ********************************

	// writes to count nibbles fall through with no effect
	always @(posedge clk) begin
		if (sys_rst) begin
			ev_mode_r  <= 1'b0;
			ev_noise_r <= 1'b0;
			ev_pol_r   <= 1'b0;
			cksel_r    <= 2'h0;
			out_en_r   <= 1'b0;
			output_channel_select_r    <= 1'b0;
			div0_r     <= `DIV_BY_1;
			div1_r     <= `DIV_BY_1;
			run_req_r  <= 2'h0;
			rld0_r     <= `RST_BYTE;
			rld1_r     <= `RST_BYTE;
			irq_en_r   <= 2'h0;
		end else if (do_wr & wr_lane) begin
			case (wr_idx)
				`IDX_EVCFG: begin
					ev_mode_r  <= wd[`EV_MODE_BIT];
					ev_noise_r <= wd[`EV_NOISE_BIT];
					ev_pol_r   <= wd[`EV_POL_BIT];
				end
				`IDX_CLKOUT: begin
					cksel_r  <= {wd[`CO_PRESCALER1_SOURCE_SELECT_BIT], wd[`CO_PRESCALER0_SOURCE_SELECT_BIT]};
					out_en_r <= wd[`CO_OE_BIT];
					output_channel_select_r  <= wd[`CO_OUTPUT_CHANNEL_SELECT_BIT];
				end
				`IDX_T0CTRL: begin
					div0_r       <= wd[`TC_DIV_HI:`TC_DIV_LO];
					run_req_r[0] <= wd[`TC_RUN_BIT];
				end
				`IDX_T1CTRL: begin
					div1_r       <= wd[`TC_DIV_HI:`TC_DIV_LO];
					run_req_r[1] <= wd[`TC_RUN_BIT];
				end
				`IDX_T0RLD_LO: rld0_r[3:0] <= wd;
				`IDX_T0RLD_HI: rld0_r[7:4] <= wd;
				`IDX_T1RLD_LO: rld1_r[3:0] <= wd;
				`IDX_T1RLD_HI: rld1_r[7:4] <= wd;
				`IDX_IRQ_EN:   irq_en_r    <= wd[1:0];
				default: ;
			endcase
		end
	end

	// ********************************
	// readback latch, flags and output
	// ********************************

	wire [1:0] flag_clr;
	wire       sel_uf;

	assign flag_clr = (do_wr & wr_lane & (wr_idx == `IDX_IRQ_FLAG)) ? wd[1:0] : 2'h0;
	assign sel_uf   = output_channel_select_r ? uf[1] : uf[0];

	// low-nibble read freezes the matching high nibble
	always @(posedge clk) begin
		if (sys_rst) begin
			hold0_r <= `RST_NIBBLE;
			hold1_r <= `RST_NIBBLE;
		end else if (ar_go & rd_hit) begin
			if (rd_idx == `IDX_T0CNT_LO)
				hold0_r <= cnt0_r[7:4];
			if (rd_idx == `IDX_T1CNT_LO)
				hold1_r <= cnt1_r[7:4];
		end
	end

	// underflow sets win over a same-cycle clear
	always @(posedge clk) begin
		if (sys_rst)
			irq_flag_r <= 2'h0;
		else
			irq_flag_r <= (irq_flag_r & ~flag_clr) | uf;
	end

	// toggle on each selected underflow; pin idles high when disabled
	always @(posedge clk) begin
		if (sys_rst) begin
			timer_output_signal <= 1'b0;
			shared_output_pin   <= 1'b1;
		end else begin
			if (sel_uf)
				timer_output_signal <= ~timer_output_signal;
			shared_output_pin <= out_en_r ? timer_output_signal : 1'b1;
		end
	end

	// requests are plain levels toward the cpu
	assign timer0_irq = irq_flag_r[0] & irq_en_r[0];
	assign timer1_irq = irq_flag_r[1] & irq_en_r[1];

endmodule // dual_programmable_timer

// *** design/dual_timer_map.vh ***
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH

// register indices; byte address is four times the index
`define IDX_EVCFG     16'hFFC0
`define IDX_CLKOUT    16'hFFC1
`define IDX_T0CTRL    16'hFFC2
`define IDX_T1CTRL    16'hFFC3
`define IDX_T0RLD_LO  16'hFFC4
`define IDX_T0RLD_HI  16'hFFC5
`define IDX_T1RLD_LO  16'hFFC6
`define IDX_T1RLD_HI  16'hFFC7
`define IDX_T0CNT_LO  16'hFFC8
`define IDX_T0CNT_HI  16'hFFC9
`define IDX_T1CNT_LO  16'hFFCA
`define IDX_T1CNT_HI  16'hFFCB
`define IDX_IRQ_EN    16'hFFE2
`define IDX_IRQ_FLAG  16'hFFF2

// timer0_event_config fields
`define EV_POL_BIT    0
`define EV_NOISE_BIT  1
`define EV_MODE_BIT   2
// clock_source_and_output_ctrl fields
`define CO_PRESCALER0_SOURCE_SELECT_BIT 0
`define CO_PRESCALER1_SOURCE_SELECT_BIT 1
`define CO_OE_BIT     2
`define CO_OUTPUT_CHANNEL_SELECT_BIT  3
// timerN_control fields
`define TC_RUN_BIT    0
`define TC_PRESET_BIT 1
`define TC_DIV_LO     2
`define TC_DIV_HI     3

// division ratio codes
`define DIV_BY_1      2'h0
`define DIV_BY_4      2'h1
`define DIV_BY_32     2'h2
`define DIV_BY_256    2'h3

// reset values
`define RST_NIBBLE    4'h0
`define RST_BYTE      8'h00

// axi responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** sim/event_pulse_source.sv ***
`timescale 1ns/1ns
// ****************************
// external count pulse source
// ****************************
module event_pulse_source (
	// clock
	input  wire  clk,
	// pin
	output logic event_input_pin
);
	// idles high, so a pulse is a falling then a rising edge
	initial begin
		event_input_pin = 1'h1;
	end
	// move the pin after an edge and hold it; short holds make glitches
	task automatic move(input logic lvl, input int hold);
		@(posedge clk);
		event_input_pin <= lvl;
		repeat (hold) @(posedge clk);
	endtask
endmodule // event_pulse_source

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`include "dual_timer_map.vh"
// ************************
// timer testbench
// ************************
module tb_top;
	logic        clk, sys_rst, low_speed_clock, high_speed_clock, rejecter_clock_2048hz;
	logic [7:0]  osc_cnt_r;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         event_input_pin, timer_output_signal, shared_output_pin, timer0_irq, timer1_irq;
	int          mismatches, cmp_count;

	dual_programmable_timer #(.ADDR_W(18)) dut (
		.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.low_speed_clock, .high_speed_clock, .rejecter_clock_2048hz, .event_input_pin,
		.timer_output_signal, .shared_output_pin, .timer0_irq, .timer1_irq
	);
	event_pulse_source src (.clk, .event_input_pin);

	// oscillators as slow levels: low period 8, high 4, rejecter 16 cycles
	always @(posedge clk) begin
		osc_cnt_r <= osc_cnt_r + 8'h01;
		low_speed_clock <= osc_cnt_r[2];
		high_speed_clock <= osc_cnt_r[1];
		rejecter_clock_2048hz <= osc_cnt_r[3];
	end
	task automatic summarize();
		if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [17:0] ad(input logic [15:0] i);
		return {i, 2'h0};
	endfunction
	function automatic int dv(input logic [1:0] c);
		return c == 2'h3 ? 256 : c == 2'h2 ? 32 : c == 2'h1 ? 4 : 1;
	endfunction
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [17:0] a, input logic [3:0] d, output logic [1:0] r);
		logic da, dw;
		da = 0;
		dw = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {28'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(da && dw)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				da = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				dw = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic w(input logic [15:0] i, input logic [3:0] d);
		logic [1:0] r;
		wr(ad(i), d, r);
		chk(r, `RESP_OKAY);
	endtask
	task automatic rc(input logic [15:0] i, input logic [3:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(ad(i), d, r);
		chk(d, {28'h0, e});
	endtask
	// low nibble first, so the high one comes from the latch
	task automatic rcnt(input logic [15:0] i, output logic [7:0] v);
		logic [31:0] lo, hi;
		logic [1:0] r;
		rd(ad(i), lo, r);
		rd(ad(i + 16'h0001), hi, r);
		v = {hi[3:0], lo[3:0]};
	endtask
	// cycles between two toggles of the output, i.e. one underflow period
	task automatic tper(output int n);
		logic o;
		o = timer_output_signal;
		while (timer_output_signal === o) @(posedge clk);
		o = timer_output_signal;
		n = 0;
		while (timer_output_signal === o) begin
			@(posedge clk);
			n++;
		end
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		summarize();
	end
	// main sequence
	initial begin
		logic [15:0] idx[7];
		logic [3:0]  msk[7], rl[4], d;
		logic [7:0]  v, h;
		logic [31:0] rdat;
		logic [1:0]  r;
		int          n, l;
		idx = '{16'hFFC0, 16'hFFC1, 16'hFFC4, 16'hFFC5, 16'hFFC6, 16'hFFC7, 16'hFFE2};
		msk = '{4'h7, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h3};
		{sys_rst, osc_cnt_r, low_speed_clock, high_speed_clock, rejecter_clock_2048hz} = {1'h1, 11'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {68'h0, 4'hF};
		void'($urandom(32'h17df29f5));
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		for (int i = 0; i < 14; i++) rc(i < 12 ? 16'hFFC0 + 16'(i) : i == 12 ? 16'hFFE2 : 16'hFFF2, 4'h0);
		for (int i = 0; i < 7; i++) begin
			d = $urandom;
			if (i > 1 && i < 6) rl[i-2] = d;
			w(idx[i], d);
			rc(idx[i], d & msk[i]);
		end
		for (int t = 0; t < 2; t++) begin
			d = $urandom;
			w(`IDX_T0CTRL + 16'(t), {d[1:0], 2'h2});
			rc(`IDX_T0CTRL + 16'(t), {d[1:0], 2'h0});
			rcnt(16'hFFC8 + 16'(2 * t), v);
			chk(v, {rl[2*t+1], rl[2*t]});
			w(16'hFFC8 + 16'(2 * t), ~v[3:0]);
			rcnt(16'hFFC8 + 16'(2 * t), v);
			chk(v, {rl[2*t+1], rl[2*t]});
		end
		wr({16'hFFD0, 2'h0}, 4'hF, r);
		chk(r, `RESP_SLVERR);
		rd({16'hFFC4, 2'h1}, rdat, r);
		chk(r, `RESP_SLVERR);
		// a write without the low byte lane is answered but ignored
		s_axi_wstrb <= 4'hE;
		w(`IDX_T0RLD_LO, ~rl[0]);
		s_axi_wstrb <= 4'hF;
		rc(`IDX_T0RLD_LO, rl[0]);
		// underflow period of timer 1 for every source and ratio
		for (int s = 0; s < 2; s++) for (int c = 0; c < 4; c++) begin
			l = $urandom_range(2);
			w(`IDX_T1RLD_LO, 4'(l));
			w(`IDX_T1RLD_HI, 4'h0);
			w(`IDX_CLKOUT, {2'h3, 1'(s), 1'h0});
			w(`IDX_T1CTRL, {2'(c), 2'h3});
			tper(n);
			chk(n, (l + 1) * dv(2'(c)) * (s ? 4 : 8));
		end
		w(`IDX_T1CTRL, 4'h3);
		w(`IDX_CLKOUT, 4'h8);
		repeat (60) begin
			@(posedge clk);
			chk(shared_output_pin, 1);
		end
		w(`IDX_CLKOUT, 4'h4);
		v = timer_output_signal;
		repeat (60) @(posedge clk);
		chk(timer_output_signal, v);
		w(`IDX_T1RLD_LO, 4'hF);
		w(`IDX_T1RLD_HI, 4'hF);
		w(`IDX_T1CTRL, 4'h3);
		repeat (200) @(posedge clk);
		w(`IDX_T1CTRL, 4'h0);
		repeat (20) @(posedge clk);
		rcnt(`IDX_T1CNT_LO, h);
		repeat (200) @(posedge clk);
		rcnt(`IDX_T1CNT_LO, v);
		chk(v, h);
		rc(`IDX_T1CTRL, 4'h0);
		w(`IDX_T1CTRL, 4'h1);
		repeat (80) @(posedge clk);
		rcnt(`IDX_T1CNT_LO, v);
		chk(h - v >= 8 && h - v <= 12, 1);
		w(`IDX_IRQ_EN, 4'h0);
		w(`IDX_T1RLD_HI, 4'h0);
		// flag left over from the period runs must not hide a missing set
		w(`IDX_IRQ_FLAG, 4'h3);
		rc(`IDX_IRQ_FLAG, 4'h0);
		w(`IDX_T1CTRL, 4'h3);
		// sixteen ticks of eight cycles reach the underflow
		repeat (150) @(posedge clk);
		rc(`IDX_IRQ_FLAG, 4'h2);
		chk(timer1_irq, 0);
		w(`IDX_IRQ_EN, 4'h3);
		chk(timer1_irq, 1);
		w(`IDX_T1CTRL, 4'h0);
		repeat (30) @(posedge clk);
		w(`IDX_IRQ_FLAG, 4'h0);
		rc(`IDX_IRQ_FLAG, 4'h2);
		w(`IDX_IRQ_FLAG, 4'h2);
		rc(`IDX_IRQ_FLAG, 4'h0);
		chk(timer1_irq, 0);
		// timer 0 counting pin edges; its source and ratio are left at odd values
		w(`IDX_T0RLD_LO, 4'h0);
		w(`IDX_T0RLD_HI, 4'h1);
		w(`IDX_CLKOUT, 4'h1);
		for (int p = 0; p < 2; p++) begin
			w(`IDX_EVCFG, 4'h4 | 4'(p));
			w(`IDX_T0CTRL, 4'hF);
			src.move(0, 20);
			src.move(1, 20);
			w(`IDX_T0CTRL, 4'hF);
			rcnt(`IDX_T0CNT_LO, v);
			chk(v, 8'h10);
			rc(`IDX_T0CNT_LO, 4'h0);
			src.move(0, 20);
			rc(`IDX_T0CNT_HI, 4'h1);
			rcnt(`IDX_T0CNT_LO, v);
			chk(v, 8'h10 - 8'(p == 0));
			src.move(1, 20);
			rcnt(`IDX_T0CNT_LO, v);
			chk(v, 8'h0F);
		end
		w(`IDX_EVCFG, 4'h6);
		src.move(0, 12);
		src.move(1, 40);
		rcnt(`IDX_T0CNT_LO, v);
		chk(v, 8'h0F);
		src.move(0, 40);
		src.move(1, 40);
		rcnt(`IDX_T0CNT_LO, v);
		chk(v, 8'h0E);
		w(`IDX_EVCFG, 4'h4);
		src.move(0, 4);
		src.move(1, 10);
		rcnt(`IDX_T0CNT_LO, v);
		chk(v, 8'h0D);
		w(`IDX_EVCFG, 4'h0);
		w(`IDX_T0CTRL, 4'h1);
		repeat (150) @(posedge clk);
		rc(`IDX_IRQ_FLAG, 4'h1);
		chk(timer0_irq, 1);
		w(`IDX_IRQ_EN, 4'h2);
		chk(timer0_irq, 0);
		sys_rst <= 1'h1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		rc(`IDX_T0CTRL, 4'h0);
		rc(`IDX_IRQ_EN, 4'h0);
		summarize();
	end
endmodule // tb_top

// *** sim/timer_assertions.sv ***
`timescale 1ns/1ns
`include "dual_timer_map.vh"
// ************************************
// bus and pin relations of the timer
// ************************************
module timer_assertions #(
	parameter ADDR_W = 18
) (
	// clock and reset
	input wire              clk,
	input wire              sys_rst,
	// register bus
	input wire              s_axi_awvalid,
	input wire              s_axi_awready,
	input wire              s_axi_wvalid,
	input wire              s_axi_wready,
	input wire [1:0]        s_axi_bresp,
	input wire              s_axi_bvalid,
	input wire              s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire [31:0]       s_axi_rdata,
	input wire [1:0]        s_axi_rresp,
	input wire              s_axi_rvalid,
	input wire              s_axi_rready,
	// pins
	input wire              timer_output_signal,
	input wire              shared_output_pin,
	input wire              timer0_irq,
	input wire              timer1_irq
);
	reg  [ADDR_W-1:0] ar_addr_r;
	wire [15:0]       ar_idx = ar_addr_r[ADDR_W-1:2];
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// keep the read address until its answer is seen
	always @(posedge clk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ar_addr_r <= s_axi_araddr;
		end
	end
	a_reset_idle: assert property ($fell(sys_rst) |-> !timer0_irq && !timer1_irq && shared_output_pin
		&& !timer_output_signal) else $error("pins not idle after reset");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
		else $error("upper read bits set");
	a_preset_reads0: assert property (s_axi_rvalid && (ar_idx == `IDX_T0CTRL || ar_idx == `IDX_T1CTRL)
		|-> !s_axi_rdata[`TC_PRESET_BIT]) else $error("preset bit read as one");
	a_misalign_err: assert property (s_axi_rvalid && ar_addr_r[1:0] != 2'h0
		|-> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("misaligned read accepted");
	a_pin_follows: assert property (!shared_output_pin |-> !$past(timer_output_signal))
		else $error("pin low without output");
	c_write_err: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
	c_out_toggle: cover property ($rose(timer_output_signal));
	c_irq0: cover property (timer0_irq);
	c_irq1: cover property (timer1_irq);
endmodule // timer_assertions

bind dual_programmable_timer timer_assertions #(.ADDR_W(ADDR_W)) chk_i (
	.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_output_signal, .shared_output_pin,
	.timer0_irq, .timer1_irq
);
